// ---- core/lso_switch_output.sv ----
// switch output controller of a level transmitter
`timescale 1ns/1ps
`default_nettype none
module lso_switch_output
  import lso_pkg::*;
#(
  parameter int VAL_W     = 32,            // measured value width, signed
  parameter int TENTH_CYC = LSO_TENTH_CYC  // cycles per tenth of a second
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    SYS_RST,
  input  wire lso_cfg_t                CFG,        // configuration parameters
  input  wire logic signed [VAL_W-1:0] ON_VALUE,   // switch-on threshold
  input  wire logic signed [VAL_W-1:0] OFF_VALUE,  // switch-off threshold
  input  wire logic signed [VAL_W-1:0] MEAS_VALUE, // selected measured variable
  input  wire lso_evt_t                EVT,        // diagnostics and block inputs
  output var  logic                    SWITCH_CLOSED, // pin drive: 1 conductive
  output var  logic                    STATUS_CLOSED  // readback of switch state
);
  // elaboration checks: comparators need a sign bit, timers a nonzero tick
  if (VAL_W < 2) begin : g_bad_width
    $error("value width too small");
  end
  if (TENTH_CYC < 1) begin : g_bad_tick
    $error("tenth period must be at least one cycle");
  end

  // whole module state
  typedef struct packed {
    lso_state_t st;   // limit state machine
    logic       out;  // conductive
    logic       stat; // readback copy
  } lso_core_t;
  lso_core_t s_q, s_d;

  // source lookup: off gives open, unknown codes treated as off
  function automatic logic src_value(input logic [3:0] sel, input lso_evt_t e);
    logic v;
    v = 1'b0;
    if (sel >= LSO_SRC_DIG && sel <= LSO_SRC_LAST) begin
      v = e.dig[3'(sel - LSO_SRC_DIG)];
    end else if (sel >= LSO_SRC_HEALTH && sel < LSO_SRC_DIG) begin
      v = e.health[1'(sel - LSO_SRC_HEALTH)];
    end
    return v;
  endfunction

  // delays above the allowed range are clamped rather than left to run long
  function automatic logic [9:0] clamp_dly(input logic [9:0] d);
    logic [9:0] c;
    c = d;
    if (d > LSO_DLY_MAX) begin
      c = LSO_DLY_MAX;
    end
    return c;
  endfunction

  // threshold conditions
  logic on_gt_off;
  logic close_cond;
  logic open_cond;
  always_comb begin
    on_gt_off = ON_VALUE > OFF_VALUE;
    if (on_gt_off) begin
      close_cond = MEAS_VALUE > ON_VALUE;
      open_cond  = MEAS_VALUE < OFF_VALUE;
    end else begin
      close_cond = MEAS_VALUE < ON_VALUE;
      open_cond  = MEAS_VALUE > OFF_VALUE;
    end
  end

  // delays only count when a variable is assigned
  logic on_run, off_run, on_done, off_done;
  logic [9:0] on_tgt, off_tgt;
  always_comb begin
    on_tgt  = CFG.limit_en ? clamp_dly(CFG.on_dly) : 10'h000;
    off_tgt = CFG.limit_en ? clamp_dly(CFG.off_dly) : 10'h000;
    on_run  = (s_q.st == LSO_ST_WAIT_ON) && close_cond;
    off_run = (s_q.st == LSO_ST_WAIT_OF) && open_cond;
  end

  lso_delay_timer #(.TENTH_CYC(TENTH_CYC)) u_on_tmr (
    .clk    (CORE_CLK),
    .rst    (SYS_RST),
    .run    (on_run),
    .target (on_tgt),
    .done   (on_done)
  );
  lso_delay_timer #(.TENTH_CYC(TENTH_CYC)) u_off_tmr (
    .clk    (CORE_CLK),
    .rst    (SYS_RST),
    .run    (off_run),
    .target (off_tgt),
    .done   (off_done)
  );

  // next state and output selection
  logic diag_hit;
  logic raw;
  always_comb begin
    s_d = s_q;
    // limit state machine runs regardless of function so it is warm on entry
    case (s_q.st)
      LSO_ST_OPEN: begin
        if (close_cond) s_d.st = LSO_ST_WAIT_ON;
      end
      LSO_ST_WAIT_ON: begin
        if (!close_cond) s_d.st = LSO_ST_OPEN;
        else if (on_done) s_d.st = LSO_ST_CLOSED;
      end
      LSO_ST_CLOSED: begin
        if (open_cond) s_d.st = LSO_ST_WAIT_OF;
      end
      LSO_ST_WAIT_OF: begin
        if (!open_cond) s_d.st = LSO_ST_CLOSED;
        else if (off_done) s_d.st = LSO_ST_OPEN;
      end
      default: s_d.st = LSO_ST_OPEN;
    endcase
    // diagnostic category match
    case (CFG.diag_sel)
      LSO_DG_ALARM: diag_hit = EVT.alarm;
      LSO_DG_BOTH:  diag_hit = EVT.alarm | EVT.warning;
      LSO_DG_WARN:  diag_hit = EVT.warning;
      default:      diag_hit = EVT.alarm;
    endcase
    // function selection
    case (CFG.func)
      LSO_FN_OFF:   raw = 1'b0;
      LSO_FN_ON:    raw = 1'b1;
      LSO_FN_DIAG:  raw = !diag_hit;
      LSO_FN_LIMIT: raw = (s_q.st == LSO_ST_CLOSED) || (s_q.st == LSO_ST_WAIT_OF);
      LSO_FN_TRACK: raw = src_value(CFG.src_sel, EVT);
      default:      raw = 1'b0;
    endcase
    // failure override during alarm
    if ((CFG.func == LSO_FN_LIMIT || CFG.func == LSO_FN_TRACK) && EVT.alarm) begin
      if (CFG.fail_mode == LSO_FL_OPEN) raw = 1'b0;
      else if (CFG.fail_mode == LSO_FL_CLOSED) raw = 1'b1;
    end
    s_d.out  = raw ^ CFG.invert;
    s_d.stat = raw ^ CFG.invert;
  end

  // state register
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) s_q <= '{st: LSO_ST_OPEN, out: 1'b0, stat: 1'b0};
    else         s_q <= s_d;
  end

  assign SWITCH_CLOSED = s_q.out;
  assign STATUS_CLOSED = s_q.stat;

  // forced functions, warning diagnostic, limit states, failure open, status, inversion
  off_forced_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_OFF && !CFG.invert) |=> !SWITCH_CLOSED)
    else $error("off function did not open output");
  on_forced_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_ON && !CFG.invert) |=> SWITCH_CLOSED)
    else $error("on function did not close output");
  diag_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_DIAG && !CFG.invert && EVT.warning && CFG.diag_sel == LSO_DG_WARN)
    |=> !SWITCH_CLOSED)
    else $error("diagnostic event did not open output");
  cancel_wait_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_WAIT_ON && !close_cond) |=> s_q.st == LSO_ST_OPEN)
    else $error("pending close not cancelled");
  hold_band_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_CLOSED && !open_cond) |=> s_q.st == LSO_ST_CLOSED)
    else $error("closed state lost inside band");
  zero_delay_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_WAIT_ON && on_tgt == 10'h000 && close_cond)[*3]
    |-> s_q.st == LSO_ST_CLOSED)
    else $error("zero delay close too slow");
  fail_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_TRACK && EVT.alarm && CFG.fail_mode == LSO_FL_OPEN && !CFG.invert)
    |=> !SWITCH_CLOSED)
    else $error("failure open not applied");
  status_match_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    STATUS_CLOSED == SWITCH_CLOSED)
    else $error("status differs from output");
  invert_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_ON && CFG.invert) |=> !SWITCH_CLOSED)
    else $error("inversion not applied");

  // diagnostic function, remaining categories
  diag_alarm_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_DIAG && !CFG.invert && CFG.diag_sel == LSO_DG_ALARM && EVT.alarm)
    |=> !SWITCH_CLOSED)
    else $error("alarm event did not open output");
  diag_both_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_DIAG && !CFG.invert && CFG.diag_sel == LSO_DG_BOTH && EVT.warning)
    |=> !SWITCH_CLOSED)
    else $error("warning did not open output in combined category");
  diag_closed_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_DIAG && !CFG.invert && !EVT.alarm && !EVT.warning)
    |=> SWITCH_CLOSED)
    else $error("diagnostic output not closed without event");

  // tracking: one digital and one health source pinned to their bits
  track_dig_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_TRACK && !CFG.invert && !EVT.alarm && CFG.src_sel == LSO_SRC_DIG)
    |=> SWITCH_CLOSED == $past(EVT.dig[0]))
    else $error("output does not follow first digital source");
  track_health_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_TRACK && !CFG.invert && !EVT.alarm && CFG.src_sel == LSO_SRC_HEALTH)
    |=> SWITCH_CLOSED == $past(EVT.health[0]))
    else $error("output does not follow first health source");
  track_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_TRACK && !CFG.invert && !EVT.alarm && CFG.src_sel == LSO_SRC_OFF)
    |=> !SWITCH_CLOSED)
    else $error("source off did not open output");

  // failure setting in limit mode, and inversion of a forced state
  limit_fail_closed_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_LIMIT && EVT.alarm && CFG.fail_mode == LSO_FL_CLOSED && !CFG.invert)
    |=> SWITCH_CLOSED)
    else $error("failure closed not applied in limit mode");
  limit_fail_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_LIMIT && EVT.alarm && CFG.fail_mode == LSO_FL_OPEN && !CFG.invert)
    |=> !SWITCH_CLOSED)
    else $error("failure open not applied in limit mode");
  off_invert_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_OFF && CFG.invert)
    |=> SWITCH_CLOSED)
    else $error("inverted off function did not close output");

  // limit output: open only once the pending open has run out
  limit_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_LIMIT && !CFG.invert && !EVT.alarm && s_q.st == LSO_ST_OPEN)
    |=> !SWITCH_CLOSED)
    else $error("limit output closed in open state");
  pending_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CFG.func == LSO_FN_LIMIT && !CFG.invert && !EVT.alarm && s_q.st == LSO_ST_WAIT_OF)
    |=> SWITCH_CLOSED)
    else $error("limit output opened before off delay");

  // threshold arming, the four arming checks written on the raw ports so that a slip in the
  // shared comparator block cannot hide behind its own expression; the two band checks use close_cond and open_cond
  rise_arm_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_OPEN && ON_VALUE > OFF_VALUE && MEAS_VALUE > ON_VALUE)
    |=> s_q.st == LSO_ST_WAIT_ON)
    else $error("rise above switch-on point not armed");
  rise_drop_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_CLOSED && ON_VALUE > OFF_VALUE && MEAS_VALUE < OFF_VALUE)
    |=> s_q.st == LSO_ST_WAIT_OF)
    else $error("drop below switch-off point not armed");
  fall_arm_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_OPEN && ON_VALUE < OFF_VALUE && MEAS_VALUE < ON_VALUE)
    |=> s_q.st == LSO_ST_WAIT_ON)
    else $error("fall below switch-on point not armed");
  fall_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_CLOSED && ON_VALUE < OFF_VALUE && MEAS_VALUE > OFF_VALUE)
    |=> s_q.st == LSO_ST_WAIT_OF)
    else $error("rise above switch-off point not armed");
  open_band_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_OPEN && !close_cond)
    |=> s_q.st == LSO_ST_OPEN)
    else $error("open state lost inside band");
  cancel_open_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_WAIT_OF && !open_cond)
    |=> s_q.st == LSO_ST_CLOSED)
    else $error("pending open not cancelled");

  // timer hygiene: a stale done would let a cancelled delay finish early
  on_clear_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !on_run
    |=> !on_done)
    else $error("switch-on timer not cleared");
  off_clear_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !off_run
    |=> !off_done)
    else $error("switch-off timer not cleared");
  on_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ($rose(on_run) && on_tgt != 10'h000)
    |=> !on_done)
    else $error("switch-on delay ended at once");
  off_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ($rose(off_run) && off_tgt != 10'h000)
    |=> !off_done)
    else $error("switch-off delay ended at once");
  // with no variable assigned both delays collapse to the bare pipeline
  unassigned_on_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_WAIT_ON && close_cond && !CFG.limit_en)[*2]
    |=> s_q.st == LSO_ST_CLOSED)
    else $error("unassigned limit still delayed close");
  unassigned_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == LSO_ST_WAIT_OF && open_cond && !CFG.limit_en)[*2]
    |=> s_q.st == LSO_ST_OPEN)
    else $error("unassigned limit still delayed open");
endmodule // lso_switch_output
`default_nettype wire

// ---- core/lso_pkg.sv ----
// package for the limit switch output controller
package lso_pkg;
  // output function selection
  typedef enum logic [2:0] {
    LSO_FN_OFF   = 3'h0,
    LSO_FN_ON    = 3'h1,
    LSO_FN_DIAG  = 3'h3,
    LSO_FN_LIMIT = 3'h2,
    LSO_FN_TRACK = 3'h6
  } lso_func_t;
  // diagnostic category that opens the output
  typedef enum logic [1:0] {
    LSO_DG_ALARM = 2'h0,
    LSO_DG_BOTH  = 2'h1,
    LSO_DG_WARN  = 2'h3
  } lso_diag_t;
  // failure behaviour during an alarm
  typedef enum logic [1:0] {
    LSO_FL_ACTUAL = 2'h0,
    LSO_FL_OPEN   = 2'h1,
    LSO_FL_CLOSED = 2'h3
  } lso_fail_t;
  // tracked source: 0 off, 1..2 health blocks, 3..10 digital outputs 1..8
  localparam logic [3:0] LSO_SRC_OFF    = 4'h0;
  localparam logic [3:0] LSO_SRC_HEALTH = 4'h1;
  localparam logic [3:0] LSO_SRC_DIG    = 4'h3;
  localparam logic [3:0] LSO_SRC_LAST   = 4'hA;
  localparam int         LSO_NUM_DIG    = 8;
  localparam int         LSO_NUM_HEALTH = 2;
  // timing: delays are set in tenths of a second, 0..1000
  localparam int         LSO_CLK_HZ     = 40000000;
  localparam int         LSO_TENTH_MS   = 100;
  localparam int         LSO_TENTH_CYC  = LSO_CLK_HZ / 1000 * LSO_TENTH_MS;
  localparam logic [9:0] LSO_DLY_MAX    = 10'h3E8;
  // configuration carrier
  typedef struct packed {
    lso_func_t   func;
    lso_diag_t   diag_sel;
    lso_fail_t   fail_mode;
    logic [3:0]  src_sel;
    logic        invert;
    logic        limit_en;
    logic [9:0]  on_dly;
    logic [9:0]  off_dly;
  } lso_cfg_t;
  // event inputs carrier
  typedef struct packed {
    logic        alarm;
    logic        warning;
    logic [LSO_NUM_HEALTH-1:0] health;
    logic [LSO_NUM_DIG-1:0]    dig;
  } lso_evt_t;
  // controller state
  typedef enum logic [1:0] {
    LSO_ST_OPEN    = 2'h0,
    LSO_ST_WAIT_ON = 2'h1,
    LSO_ST_CLOSED  = 2'h3,
    LSO_ST_WAIT_OF = 2'h2
  } lso_state_t;
endpackage : lso_pkg

// ---- core/lso_delay_timer.sv ----
// delay timer counting tenths of a second
`timescale 1ns/1ps
`default_nettype none
module lso_delay_timer
  import lso_pkg::*;
#(
  parameter int TENTH_CYC = LSO_TENTH_CYC  // cycles per tenth of a second
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,     // count while high, clear when low
  input  wire logic [9:0] target,  // tenths to wait
  output var  logic       done     // target reached, held while run
);
  // elaboration check: a zero tick would never advance the tenths counter
  if (TENTH_CYC < 1) begin : g_bad_tick
    $error("tenth period must be at least one cycle");
  end
  localparam int PW = $clog2(TENTH_CYC + 1);
  typedef struct packed {
    logic [PW-1:0] pre;    // prescaler
    logic [9:0]    tenths; // elapsed tenths
    logic          done;
  } lso_tmr_t;
  lso_tmr_t s_q, s_d;
  // prescaler ticks tenths; zero target finishes at once
  always_comb begin
    s_d = s_q;
    if (!run) begin
      s_d = '0;
    end else if (s_q.tenths >= target) begin
      s_d.done = 1'b1;
    end else if (s_q.pre == PW'(TENTH_CYC - 1)) begin
      s_d.pre    = '0;
      s_d.tenths = s_q.tenths + 10'h001;
    end else begin
      s_d.pre = s_q.pre + PW'(1);
    end
  end
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_q <= '0;
    else     s_q <= s_d;
  end
  assign done = s_q.done;
endmodule // lso_delay_timer
`default_nettype wire

// ---- testbench/lso_load_model.sv ----
// model of the external load wired to the switch output
`timescale 1ns/1ps
`default_nettype none
module lso_load_model (
  input  wire logic drive_closed, // switch pin, 1 conductive
  output var  logic load_on       // current flows through the load
);
  // a passive load: current flows only while the contact conducts
  always_comb begin
    load_on = drive_closed;
  end
endmodule // lso_load_model
`default_nettype wire

// ---- testbench/limit_switch_output_tb_top.sv ----
// self-checking bench for the switch output controller
`timescale 1ns/1ps
`default_nettype none
module limit_switch_output_tb_top;
  import lso_pkg::*;
  typedef struct packed {
    lso_func_t   fn;   // output function
    lso_diag_t   dg;   // diagnostic category
    lso_fail_t   fl;   // failure behaviour
    logic [3:0]  src;  // tracked source
    logic        inv;  // inversion
    lso_evt_t    ev;   // events and block inputs
    logic [31:0] meas; // measured value
    logic        exp;  // expected switch state
  } lso_row_t;
  // thresholds of the table: on 100, off 50; values 120, 70 (band), 30
  localparam lso_row_t ROWS [22] = '{
    '{LSO_FN_OFF, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'hFFF, 32'h78, 1'h0},
    '{LSO_FN_OFF, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h1, 12'h000, 32'h78, 1'h1},
    '{LSO_FN_ON, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h000, 32'h1E, 1'h1},
    '{LSO_FN_DIAG, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h800, 32'h0, 1'h0},
    '{LSO_FN_DIAG, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h400, 32'h0, 1'h1},
    '{LSO_FN_DIAG, LSO_DG_BOTH, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h400, 32'h0, 1'h0},
    '{LSO_FN_DIAG, LSO_DG_BOTH, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h000, 32'h0, 1'h1},
    '{LSO_FN_DIAG, LSO_DG_WARN, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h800, 32'h0, 1'h1},
    '{LSO_FN_DIAG, LSO_DG_WARN, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h400, 32'h0, 1'h0},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h1, 1'h0, 12'h100, 32'h0, 1'h1},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h2, 1'h0, 12'h100, 32'h0, 1'h0},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'hA, 1'h0, 12'h080, 32'h0, 1'h1},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h3, 1'h0, 12'h080, 32'h0, 1'h0},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h3FF, 32'h0, 1'h0},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_OPEN, 4'h3, 1'h0, 12'h801, 32'h0, 1'h0},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_CLOSED, 4'h3, 1'h0, 12'h800, 32'h0, 1'h1},
    '{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h3, 1'h0, 12'h801, 32'h0, 1'h1},
    '{LSO_FN_LIMIT, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h000, 32'h78, 1'h1},
    '{LSO_FN_LIMIT, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h000, 32'h46, 1'h1},
    '{LSO_FN_LIMIT, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h000, 32'h1E, 1'h0},
    '{LSO_FN_LIMIT, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h000, 32'h46, 1'h0},
    '{LSO_FN_LIMIT, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h1, 12'h000, 32'h78, 1'h0}};
  logic               CORE_CLK;     // 40 MHz
  logic               SYS_RST;      // async, active high
  lso_cfg_t           cfg;          // configuration
  lso_evt_t           evt;          // events
  logic signed [31:0] on_v;         // switch-on threshold
  logic signed [31:0] off_v;        // switch-off threshold
  logic signed [31:0] meas;         // measured value
  logic               sw_closed;    // pin drive
  logic               st_closed;    // readback
  logic               load_on;      // load current
  logic               en;           // limit assigned
  logic [9:0]         don;          // switch-on delay, tenths
  logic [9:0]         doff;         // switch-off delay, tenths
  int                 miscompares;  // mismatches seen
  int                 total_checks; // comparisons made
  int                 cycles;       // run length guard
  // one tenth of a second is shortened to 4 cycles to keep the run brief
  lso_switch_output #(.TENTH_CYC(4)) lso_switch_output_inst (.CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST), .CFG(cfg), .ON_VALUE(on_v), .OFF_VALUE(off_v), .MEAS_VALUE(meas),
    .EVT(evt), .SWITCH_CLOSED(sw_closed), .STATUS_CLOSED(st_closed));
  lso_load_model lso_load_model_inst (.drive_closed(sw_closed), .load_on(load_on));
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // drive a row at a rising edge, wait n cycles, compare both outputs
  task automatic run(input lso_row_t r, input int n);
    @(posedge CORE_CLK);
    cfg <= '{r.fn, r.dg, r.fl, r.src, r.inv, en, don, doff};
    evt <= r.ev;
    meas <= r.meas;
    repeat (n) @(posedge CORE_CLK);
    #1;
    chk(sw_closed, r.exp);
    chk(st_closed, r.exp);
  endtask
  function automatic lso_row_t lr(input logic [31:0] m, input logic e);
    return '{LSO_FN_LIMIT, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'h0, 1'h0, 12'h000, m, e};
  endfunction
  initial begin
    CORE_CLK = 1'h0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  // guard against a hang; the tests need some 270 cycles
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    SYS_RST = 1'h1;
    cfg = '0;
    evt = '0;
    on_v = 32'sh64;
    off_v = 32'sh32;
    meas = '0;
    en = 1'h1;
    don = 10'h0;
    doff = 10'h0;
    repeat (2) @(posedge CORE_CLK);
    chk(sw_closed, 1'h0);
    SYS_RST <= 1'h0;
    foreach (ROWS[i]) run(ROWS[i], 6);
    don = 10'h2;
    doff = 10'h1;
    run(lr(32'h1E, 1'h0), 10);
    run(lr(32'h78, 1'h0), 5);
    run(lr(32'h78, 1'h1), 9);
    run(lr(32'h1E, 1'h1), 4);
    run(lr(32'h1E, 1'h0), 8);
    run(lr(32'h78, 1'h0), 6);
    run(lr(32'h46, 1'h0), 14);
    en = 1'h0;
    run(lr(32'h78, 1'h1), 6);
    chk(load_on, 1'h1);
    en = 1'h1;
    don = 10'h0;
    doff = 10'h0;
    @(posedge CORE_CLK);
    on_v <= 32'sh32;
    off_v <= 32'sh64;
    run(lr(32'h78, 1'h0), 6);
    run(lr(32'h46, 1'h0), 6);
    run(lr(32'h1E, 1'h1), 6);
    // alarm forces a closed limit output open; an out-of-range source reads open
    run('{LSO_FN_LIMIT, LSO_DG_ALARM, LSO_FL_OPEN, 4'h0, 1'h0, 12'h800, 32'h1E, 1'h0},
        3);
    run('{LSO_FN_TRACK, LSO_DG_ALARM, LSO_FL_ACTUAL, 4'hB, 1'h0, 12'h3FF, 32'h1E, 1'h0},
        3);
    @(posedge CORE_CLK);
    SYS_RST <= 1'h1;
    @(posedge CORE_CLK);
    #1;
    chk(sw_closed, 1'h0);
    chk(st_closed, 1'h0);
    @(posedge CORE_CLK);
    SYS_RST <= 1'h0;
    run(lr(32'h1E, 1'h1), 6);
    report_and_stop();
  end
endmodule // limit_switch_output_tb_top
`default_nettype wire
